// >>> fks_pkg.sv
/*
 * Constants, code words and carrier types for the FSK keepalive transmit sequencer.
 * Assumes a single 50 MHz system clock. All timing counts are derived from that rate.
 */
// How it works
// - Chips are sent by binary FSK, a choice between two tones only.
// - The mark tone is 131.25 kHz, held within its narrow tolerance band.
// - The space tone is 143.75 kHz, held within its narrow tolerance band.
// - Each chip holds its tone for 5.12 ms.
// - A zero word is +1,+1,+1,-1,-1,-1,+1,-1,-1,+1,-1, with +1 meaning mark.
// - A one word starts -1,-1,-1,+1,+1,+1,-1,+1,+1.
// - A packet is three identical words of its bit, 33 chips.
// - The burst window lasts three words, 168.96 ms.
// - After each packet the line stays silent for sixteen words, 901.12 ms.
// - Packet and quiet window repeat forever.
// - Both tones come from one clocked phase source, so switching is phase continuous.
`default_nettype none
package fks_pkg;
    localparam int  CLK_PERIOD_NS = 20;
    localparam real CLK_HZ        = 1.0e9 / CLK_PERIOD_NS;

    localparam real MARK_TONE_FREQ_KHZ  = 131.25;
    localparam real SPACE_TONE_FREQ_KHZ = 143.75;
    localparam real CHIP_PERIOD_MS      = 5.12;
    localparam real BURST_WINDOW_MS     = 168.96;
    localparam real QUIET_WINDOW_MS     = 901.12;

    localparam int PHASE_W = 32;
    // Phase increments of the shared accumulator, rounded to the nearest step.
    localparam logic [PHASE_W-1:0] MARK_INC  =
        PHASE_W'(longint'(MARK_TONE_FREQ_KHZ * 1.0e3 * (2.0 ** PHASE_W) / CLK_HZ));
    localparam logic [PHASE_W-1:0] SPACE_INC =
        PHASE_W'(longint'(SPACE_TONE_FREQ_KHZ * 1.0e3 * (2.0 ** PHASE_W) / CLK_HZ));

    localparam int CHIP_CYCLES = int'(CHIP_PERIOD_MS * 1.0e6 / CLK_PERIOD_NS);
    localparam int WORD_CHIPS  = 11;
    localparam int BURST_CHIPS = int'(BURST_WINDOW_MS / CHIP_PERIOD_MS);
    localparam int QUIET_CHIPS = int'(QUIET_WINDOW_MS / CHIP_PERIOD_MS);

    // First chip in the top bit; a set bit selects the mark tone.
    localparam logic [WORD_CHIPS-1:0] LOGIC_ZERO_CHIP_WORD = 11'h712;
    localparam logic [WORD_CHIPS-1:0] LOGIC_ONE_CHIP_WORD  = ~LOGIC_ZERO_CHIP_WORD;

    localparam int  FIFO_DEPTH = 32;
    localparam logic IDLE_BIT_RST = 1'b0;

    typedef struct packed {
        logic active;
        logic mark;
        logic wave;
    } fks_tone_t;
endpackage
`default_nettype wire

// >>> fks_keepalive_tx.sv
/*
 * Bit FIFO and the FSK keepalive sequencer that drives the front-end tone input.
 * Assumes inputs are synchronous to mclk; the front-end takes the square tone on tone_out.wave.
 */
`timescale 1ns/1ps
`default_nettype none

module fks_fifo
    import fks_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    output var  logic [WIDTH-1:0] out_data,
    output var  logic             out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fks_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             rdy_r, rdy_nxt;
    logic             push, pop;

    assign push      = in_valid && rdy_r;
    assign pop       = out_valid && out_ready;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem[rd_r];
    assign in_ready  = rdy_r;

    always_comb
    begin
        wr_nxt  = push ? wr_r + 1'b1 : wr_r;
        rd_nxt  = pop ? rd_r + 1'b1 : rd_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        rdy_nxt = (cnt_nxt != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b1;
        end
        else
        begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_r] <= in_data;
    end
endmodule // fks_fifo

module fks_keepalive_tx
    import fks_pkg::*;
#(
    parameter int CHIP_CYC = CHIP_CYCLES
)(
    input  wire logic      mclk,
    input  wire logic      rst_n,
    input  wire logic      bit_data,
    input  wire logic      bit_valid,
    output var  logic      bit_ready,
    input  wire logic      idle_bit,
    output var  fks_tone_t tone_out,
    output var  logic      packet_start
);
    if (CHIP_CYC < 2) begin : g_chk
        $error("fks_keepalive_tx chip period must be at least 2 cycles");
    end

    typedef enum logic [1:0] {ST_LOAD, ST_BURST, ST_QUIET} fks_state_t;

    // Chip of a packet's word: 1 selects the mark tone.
    function automatic logic chip_is_mark(input logic bit_val, input logic [3:0] idx);
        logic [WORD_CHIPS-1:0] word;
        word = bit_val ? LOGIC_ONE_CHIP_WORD : LOGIC_ZERO_CHIP_WORD;
        return word[4'(WORD_CHIPS - 1) - idx];
    endfunction

    fks_state_t         state_r, state_nxt;
    logic [31:0]        cyc_r, cyc_nxt;
    logic [7:0]         chip_r, chip_nxt;
    logic [3:0]         wchip_r, wchip_nxt;
    logic               bit_r, bit_nxt;
    logic [PHASE_W-1:0] acc_r, acc_nxt;
    fks_tone_t          tone_r, tone_nxt;
    logic               start_r, start_nxt;
    logic               f_data, f_valid, f_ready;
    logic               chip_end;

    fks_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (mclk),
        .rst_n     (rst_n),
        .in_data   (bit_data),
        .in_valid  (bit_valid),
        .in_ready  (bit_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_ready)
    );

    assign f_ready  = (state_r == ST_LOAD);
    assign chip_end = (cyc_r == 32'(CHIP_CYC - 1));

    always_comb
    begin
        state_nxt = state_r;
        cyc_nxt   = chip_end ? '0 : cyc_r + 1'b1;
        chip_nxt  = chip_r;
        wchip_nxt = wchip_r;
        bit_nxt   = bit_r;
        start_nxt = 1'b0;
        case (state_r)
            ST_LOAD:
            begin
                // An empty queue still yields a packet, so the keepalive never stops.
                bit_nxt   = f_valid ? f_data : idle_bit;
                state_nxt = ST_BURST;
                start_nxt = 1'b1;
                cyc_nxt   = '0;
                chip_nxt  = '0;
                wchip_nxt = '0;
            end
            ST_BURST:
            begin
                if (chip_end)
                begin
                    wchip_nxt = (wchip_r == 4'(WORD_CHIPS - 1)) ? '0 : wchip_r + 1'b1;
                    chip_nxt  = chip_r + 1'b1;
                    if (chip_r == 8'(BURST_CHIPS - 1))
                    begin
                        state_nxt = ST_QUIET;
                        chip_nxt  = '0;
                    end
                end
            end
            ST_QUIET:
            begin
                if (chip_end)
                begin
                    chip_nxt = chip_r + 1'b1;
                    if (chip_r == 8'(QUIET_CHIPS - 1))
                        state_nxt = ST_LOAD;
                end
            end
            default:
            begin
                state_nxt = ST_LOAD;
            end
        endcase
        tone_nxt.active = (state_nxt == ST_BURST);
        tone_nxt.mark   = chip_is_mark(bit_nxt, wchip_nxt);
        // One accumulator serves both tones; only its step changes, so phase is continuous.
        acc_nxt         = acc_r + (tone_nxt.mark ? MARK_INC : SPACE_INC);
        tone_nxt.wave   = tone_nxt.active && acc_nxt[PHASE_W-1];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_LOAD;
            cyc_r   <= '0;
            chip_r  <= '0;
            wchip_r <= '0;
            bit_r   <= IDLE_BIT_RST;
            acc_r   <= '0;
            tone_r  <= '0;
            start_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cyc_r   <= cyc_nxt;
            chip_r  <= chip_nxt;
            wchip_r <= wchip_nxt;
            bit_r   <= bit_nxt;
            acc_r   <= acc_nxt;
            tone_r  <= tone_nxt;
            start_r <= start_nxt;
        end
    end

    assign tone_out     = tone_r;
    assign packet_start = start_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // The accumulator stands still in reset, so a step is only judged when the edge before was out of reset.
    a_mark_step: assert property ($past(rst_n) && tone_r.mark |-> acc_r == $past(acc_r) + MARK_INC)
        else $error("mark tone phase step wrong");
    a_space_step: assert property ($past(rst_n) && !tone_r.mark |-> acc_r == $past(acc_r) + SPACE_INC)
        else $error("space tone phase step wrong");
    a_two_tones: assert property (tone_r.active |->
                                  (tone_r.mark == (bit_r ^ LOGIC_ZERO_CHIP_WORD[4'(WORD_CHIPS - 1) - wchip_r])))
        else $error("tone does not follow chip value");
    a_chip_hold: assert property ((state_r == ST_BURST) && !chip_end |=> $stable(tone_r.mark))
        else $error("tone changed inside a chip");
    // The sampled reset keeps the releasing edge, still in reset for the logic, out of the antecedent.
    a_zero_start: assert property (rst_n && (state_r == ST_LOAD) && !bit_nxt |=> tone_r.mark [*3])
        else $error("zero word must open with three marks");
    a_one_start: assert property (rst_n && (state_r == ST_LOAD) && bit_nxt |=> !tone_r.mark [*3])
        else $error("one word must open with three spaces");
    a_one_tail: assert property ((state_r == ST_BURST) && bit_r && wchip_r == 4'(WORD_CHIPS - 1) |-> tone_r.mark)
        else $error("one word must end with mark");
    a_bit_stable: assert property ((state_r == ST_BURST) |=> $stable(bit_r))
        else $error("packet bit changed inside a burst");
    a_burst_end: assert property ((state_r == ST_BURST) && chip_end && chip_r == 8'(BURST_CHIPS - 1) |=>
                                  (state_r == ST_QUIET) && !tone_r.active)
        else $error("burst did not end after 33 chips");
    a_quiet_silent: assert property ((state_r == ST_QUIET) |-> !tone_r.active && !tone_r.wave)
        else $error("line not silent in quiet window");
    a_loop_back: assert property ((state_r == ST_QUIET) && chip_end && chip_r == 8'(QUIET_CHIPS - 1) |=>
                                  (state_r == ST_LOAD) ##1 (state_r == ST_BURST) && packet_start)
        else $error("quiet window did not restart a packet");
    a_phase_cont: assert property ($changed(tone_r.mark) |-> acc_r - $past(acc_r) ==
                                   (tone_r.mark ? MARK_INC : SPACE_INC))
        else $error("phase jumped on tone switch");

    c_one_packet: cover property ((state_r == ST_LOAD) && bit_nxt ##1 (state_r == ST_BURST));
    c_zero_packet: cover property ((state_r == ST_LOAD) && !bit_nxt ##1 (state_r == ST_BURST));
    c_idle_fill: cover property ((state_r == ST_LOAD) && !f_valid);
    c_fifo_full: cover property (!bit_ready);
endmodule // fks_keepalive_tx

`default_nettype wire

// >>> fks_afe_model.sv
/*
 * Passive model of the front-end tone input: it records chips, burst and quiet lengths.
 * Assumes it sees the sequencer's tone_out and packet_start and shares its chip length.
 */
`timescale 1ns/1ps
`default_nettype none
module fks_afe_model
    import fks_pkg::*;
#(
    parameter int CHIP = 8
)(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire fks_tone_t   tone_out,
    input  wire logic        packet_start,
    output var  logic [32:0] chips,
    output var  int          burst_len,
    output var  int          quiet_len,
    output var  int          n_bad,
    output var  logic        done
);
    logic prev;
    logic prev_mark;
    int   bcnt;
    int   qcnt;
    int   pos;
    assign pos = prev ? bcnt : 0;
    // Chips are sampled mid-chip, so an edge slip of a cycle still reads the right tone.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {prev, prev_mark, done, chips} <= '0;
            {bcnt, qcnt, burst_len, quiet_len, n_bad} <= '0;
        end
        else
        begin
            prev      <= tone_out.active;
            prev_mark <= tone_out.mark;
            done      <= 1'b0;
            if (packet_start != (tone_out.active && !prev))
                n_bad <= n_bad + 1;
            if (tone_out.active)
            begin
                bcnt <= pos + 1;
                if (!prev)
                    quiet_len <= qcnt;
                if (pos % CHIP == CHIP / 2)
                    chips <= {chips[31:0], tone_out.mark};
                if (prev && (pos % CHIP != 0) && (tone_out.mark != prev_mark))
                    n_bad <= n_bad + 1;
            end
            else
            begin
                qcnt <= prev ? 1 : qcnt + 1;
                if (prev)
                begin
                    burst_len <= bcnt;
                    done      <= 1'b1;
                end
                if (tone_out.wave)
                    n_bad <= n_bad + 1;
            end
        end
    end
endmodule // fks_afe_model
`default_nettype wire

// >>> fks_keepalive_tx_tb.sv
/*
 * Self-checking bench for the keepalive sequencer with a short chip length.
 * Assumes the front-end model beside it and the hand-over timing of the sequencer.
 */
`timescale 1ns/1ps
`default_nettype none
module fks_keepalive_tx_tb;
    import fks_pkg::*;
    localparam int          C  = 8;
    localparam logic [10:0] ZW = 11'h712;
    logic        mclk      = 1'b0;
    logic        rst_n     = 1'b0;
    logic        bit_data  = 1'b0;
    logic        bit_valid = 1'b0;
    logic        idle_bit  = 1'b0;
    logic        bit_ready;
    fks_tone_t   tone_out;
    logic        packet_start;
    logic [32:0] chips;
    int          burst_len;
    int          quiet_len;
    int          n_bad;
    logic        done;
    int          n_mismatch  = 0;
    int          checks_done = 0;
    always #10 mclk = ~mclk;
    fks_keepalive_tx #(.CHIP_CYC(C)) dut_u (.mclk(mclk), .rst_n(rst_n), .bit_data(bit_data),
        .bit_valid(bit_valid), .bit_ready(bit_ready), .idle_bit(idle_bit), .tone_out(tone_out),
        .packet_start(packet_start));
    fks_afe_model #(.CHIP(C)) afe_u (.mclk(mclk), .rst_n(rst_n), .tone_out(tone_out),
        .packet_start(packet_start), .chips(chips), .burst_len(burst_len), .quiet_len(quiet_len),
        .n_bad(n_bad), .done(done));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wait_pkt(input logic b, input logic qchk);
        int i;
        for (i = 0; i < 2000; i++)
        begin
            @(posedge mclk);
            if (done === 1'b1)
                break;
        end
        check(i < 2000, 1);
        check(chips, b ? {3{~ZW}} : {3{ZW}});
        check(burst_len, 33 * C);
        if (qchk)
            check(quiet_len, 176 * C + 1);
    endtask
    task automatic test_reset;
        #1;
        check({bit_ready, tone_out, packet_start}, 5'h10);
    endtask
    // Fills the queue during a quiet window, tries one push too many, then drains it.
    task automatic test_fill_drain;
        int k;
        for (k = 0; k < 33; k++)
        begin
            @(posedge mclk);
            bit_valid <= 1'b1;
            bit_data  <= (k % 3 == 0) && (k < 32);
        end
        @(posedge mclk);
        bit_valid <= 1'b0;
        idle_bit  <= 1'b1;
        #1;
        check(bit_ready, 0);
        for (k = 0; k < 32; k++)
            wait_pkt(k % 3 == 0, 1);
        wait_pkt(1, 1);
        check(bit_ready, 1);
        check(n_bad, 0);
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        test_reset();
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        wait_pkt(0, 0);
        test_fill_drain();
        report_and_stop();
    end
    initial
    begin
        repeat (80000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule // fks_keepalive_tx_tb
`default_nettype wire
